// >>> bstc_host.sv
// host model: one-cycle register strobes, data read one cycle later
`timescale 1ns/1ps
module bstc_host (
  input  wire logic                    sys_clk,    // clock
  output bstc_pkg::bstc_reg_req_t      reg_req,    // host port
  input  wire logic [15:0]             reg_rdata_q // read data
);
  initial reg_req = '0;
  // one start bit per write, never a start while a test runs
  task automatic wr(input logic [5:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    reg_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge sys_clk);
    reg_req.wr    <= 1'b0;
    reg_req.wdata <= ~d;
  endtask : wr
  task automatic rd(input logic [5:0] a, output logic [15:0] d);
    @(posedge sys_clk);
    reg_req <= '{addr: a, wdata: reg_req.wdata, wr: 1'b0, rd: 1'b1};
    @(posedge sys_clk);
    reg_req.rd <= 1'b0;
    #1 d = reg_rdata_q;
  endtask : rd
endmodule : bstc_host

// >>> bstc_map.svh
// register offsets, field positions, reset values and step counts
`ifndef BSTC_MAP_SVH
`define BSTC_MAP_SVH
`define BSTC_OFF_CMD      6'h03
`define BSTC_OFF_CFG6     6'h18
`define BSTC_OFF_CFG3     6'h19
`define BSTC_OFF_CFG7     6'h19
`define BSTC_OFF_STATUS   6'h1c
`define BSTC_OFF_IMASK2   6'h1d
`define BSTC_OFF_ISTAT2   6'h1e
`define BSTC_OFF_FAILVEC  6'h20
`define BSTC_WIN_LIMIT    6'h1f
`define BSTC_CMD_SWRESET  0
`define BSTC_CMD_PL_START 7
`define BSTC_CMD_RAM_START 9
`define BSTC_CMD_CLR_STAT 10
`define BSTC_CMD_RESUME   11
`define BSTC_CFG3_GATE    15
`define BSTC_CFG7_HALTEN  4
`define BSTC_CFG6_WIN64   2
`define BSTC_IST2_DONE    1
`define BSTC_ST_PL_DONE   15
`define BSTC_ST_PL_BUSY   14
`define BSTC_ST_PL_PASS   13
`define BSTC_ST_PL_ABORT  12
`define BSTC_ST_PL_MARK   11
`define BSTC_ST_RAM_FAIL  2
`define BSTC_ST_RAM_DONE  1
`define BSTC_CFG_RST      16'h0000
`define BSTC_STATUS_CLR   16'h0000
`define BSTC_PL_VEC_CYC   3'h7
`define BSTC_MEM_WR_LAST  3'h2
`define BSTC_MEM_RD_LAST  3'h1
`define BSTC_PL_VECTORS   4000
`define BSTC_MEM_WORDS    4096
`endif

// >>> bstc_pkg.sv
// types shared by the self-test sequencer
package bstc_pkg;
  typedef enum logic [2:0] {
    BSTC_IDLE_MODE, BSTC_CONTROLLER, BSTC_TERMINAL,
    BSTC_WORD_MON, BSTC_MSG_MON, BSTC_TERM_MON
  } bstc_mode_t;
  typedef enum logic [1:0] {
    ST_IDLE, ST_PL_RUN, ST_MEM_WR, ST_MEM_RD
  } bstc_state_t;
  typedef struct packed {
    logic [5:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } bstc_reg_req_t;
  typedef struct packed {
    logic [15:0] addr;
    logic [15:0] wdata;
    logic        we;
    logic        re;
  } bstc_mem_req_t;
endpackage : bstc_pkg

// >>> bstc_top.sv
// self-test sequencer: protocol vectors, ram walk, status and halt control
//
// Summary of operation
// - protocol test: eight clocks per vector
// - ram test: ten clocks per word
// - ram write three clocks, read two
// - master clear rising edge starts protocol test
// - software reset starts no test
// - host write during test not carried out
// - address parity error ignored by tests
// - status reads 4800h while protocol running
// - status A800h on protocol pass
// - status 8800h on protocol fail
// - command bit 10 clears status
// - halt allow plus mode command in terminal mode: go offline
// - test from halted state returns online
// - command bit 11 resumes online, no test
// - command bit 9 starts ram test
// - command bit 7 starts protocol test
// - start ignored in terminal, message or terminal monitor mode, and online controller or word monitor, unless terminal or monitor halted
// - feature gate bit 15 required for commanded tests
// - upper window needs config six bit 2
// - write aborts test, sets abort bit in protocol test
// - abort clears configuration like software reset
// - test done sets interrupt status bit 1
//
// The strobed register port was decided locally.
`timescale 1ns/1ps
`include "bstc_map.svh"

module bstc_top #(
  parameter int PL_VECTORS = `BSTC_PL_VECTORS,
  parameter int MEM_WORDS  = `BSTC_MEM_WORDS
) (
  input  wire logic                   sys_clk,         // 40 mhz clock
  input  wire logic                   resetn,          // async reset
  input  wire logic                   master_clear_n,  // reset pin
  input  wire bstc_pkg::bstc_reg_req_t reg_req,        // register access
  output logic [15:0]                 reg_rdata_q,     // read data
  input  wire bstc_pkg::bstc_mode_t   dev_mode,        // operating mode
  input  wire logic                   dev_online,      // bus activity
  input  wire logic                   monitor_halted_state, // mon halt
  input  wire logic                   init_test_cmd,   // mode command
  input  wire logic                   pl_mismatch,     // vector failed
  output logic [15:0]                 pl_vec_q,        // vector index
  output logic [2:0]                  pl_phase_q,      // vector clock
  output bstc_pkg::bstc_mem_req_t     mem_req_q,       // ram access
  input  wire logic [15:0]            mem_rdata,       // ram data
  output logic                        test_busy_q,     // test running
  output logic                        terminal_halted_state, // offline
  output logic                        irq_q            // done request
);

  bstc_pkg::bstc_state_t state_q;
  logic [2:0]  cyc_q;
  logic        pass_q;
  logic        both_q;
  logic        fail_q;
  logic        from_halt_q;
  logic        mclr_s1_q, mclr_s2_q, mclr_s3_q;
  logic [15:0] cfg6_q, cfg37_q, status_q, imask2_q, istat2_q;
  logic [15:0] failvec_q;
  logic        halted_q;

  logic        rd_hit, wr_hit, cmd_wr, abort, por_start;
  logic        pl_go, ram_go, pl_end, ram_end, pl_bad;
  logic [15:0] wd;
  logic [15:0] expect_data;
  logic        start_taken;

  // the mode list comes from the mode field of the rest of the device
  // a halted terminal or monitor may always start; online controller or word monitor may not
  function automatic logic start_ok(
    input bstc_pkg::bstc_mode_t mode,
    input logic online,
    input logic thalt,
    input logic mhalt
  );
    logic ok;
    ok = 1'b0;
    case (mode)
      bstc_pkg::BSTC_IDLE_MODE:  ok = 1'b1;
      bstc_pkg::BSTC_CONTROLLER: ok = !online;
      bstc_pkg::BSTC_WORD_MON:   ok = !online;
      default:                   ok = 1'b0;
    endcase
    return ok || thalt || mhalt;
  endfunction : start_ok

  function automatic logic [15:0] pattern(
    input logic [15:0] addr,
    input logic        inv
  );
    return inv ? ~addr : addr;
  endfunction : pattern

  assign wd     = reg_req.wdata;
  assign rd_hit = reg_req.rd;
  assign wr_hit = reg_req.wr;
  // any write while busy kills the test and is itself dropped
  // reads are free at any time; of host accesses only a write ends a test
  assign abort  = wr_hit && (state_q != bstc_pkg::ST_IDLE);
  assign cmd_wr = wr_hit && !abort
                  && (reg_req.addr == `BSTC_OFF_CMD);

  // parity on the terminal address pins is not an input here at all
  assign por_start = mclr_s2_q && !mclr_s3_q;

  // power-on run is not gated: the gate is cleared by the reset itself
  assign pl_go  = por_start
                  || (cmd_wr && wd[`BSTC_CMD_PL_START]
                      && cfg37_q[`BSTC_CFG3_GATE]
                      && start_ok(dev_mode, dev_online,
                                  halted_q, monitor_halted_state));
  assign ram_go = cmd_wr && wd[`BSTC_CMD_RAM_START]
                  && cfg37_q[`BSTC_CFG3_GATE]
                  && start_ok(dev_mode, dev_online,
                              halted_q, monitor_halted_state);

  assign pl_end = (state_q == bstc_pkg::ST_PL_RUN)
                  && (cyc_q == `BSTC_PL_VEC_CYC)
                  && (pl_vec_q == 16'(PL_VECTORS - 1));
  assign pl_bad = fail_q || both_q
                  || ((cyc_q == `BSTC_PL_VEC_CYC) && pl_mismatch);
  assign ram_end = (state_q == bstc_pkg::ST_MEM_RD)
                   && (cyc_q == `BSTC_MEM_RD_LAST) && pass_q
                   && (mem_req_q.addr == 16'(MEM_WORDS - 1));

  assign expect_data = pattern(mem_req_q.addr, pass_q);

  // a start is taken only from idle; a new pin edge mid-test is dropped
  assign start_taken = (state_q == bstc_pkg::ST_IDLE) && (pl_go || ram_go);

  // master clear pin: second and third stages feed the edge detector
  // limitation: a low pulse shorter than one clock may go unseen
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      mclr_s1_q <= 1'b0;
      mclr_s2_q <= 1'b0;
      mclr_s3_q <= 1'b0;
    end else begin
      mclr_s1_q <= master_clear_n;
      mclr_s2_q <= mclr_s1_q;
      mclr_s3_q <= mclr_s2_q;
    end
  end

  // sequencer
  // one test at a time: starts are looked at only in idle
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      state_q <= bstc_pkg::ST_IDLE;
      cyc_q   <= 3'h0;
      pass_q  <= 1'b0;
    end else begin
      case (state_q)
        bstc_pkg::ST_IDLE: begin
          cyc_q  <= 3'h0;
          pass_q <= 1'b0;
          if (pl_go)
            state_q <= bstc_pkg::ST_PL_RUN;
          else if (ram_go)
            state_q <= bstc_pkg::ST_MEM_WR;
        end
        bstc_pkg::ST_PL_RUN: begin
          cyc_q <= cyc_q + 3'h1;
          if (abort || pl_end)
            state_q <= bstc_pkg::ST_IDLE;
        end
        bstc_pkg::ST_MEM_WR: begin
          if (abort) begin
            state_q <= bstc_pkg::ST_IDLE;
          end else if (cyc_q == `BSTC_MEM_WR_LAST) begin
            cyc_q   <= 3'h0;
            state_q <= bstc_pkg::ST_MEM_RD;
          end else begin
            cyc_q <= cyc_q + 3'h1;
          end
        end
        bstc_pkg::ST_MEM_RD: begin
          if (abort || ram_end) begin
            state_q <= bstc_pkg::ST_IDLE;
          end else if (cyc_q == `BSTC_MEM_RD_LAST) begin
            cyc_q   <= 3'h0;
            pass_q  <= !pass_q;
            state_q <= bstc_pkg::ST_MEM_WR;
          end else begin
            cyc_q <= cyc_q + 3'h1;
          end
        end
        default: state_q <= bstc_pkg::ST_IDLE;
      endcase
    end
  end

  // vector index and failure record
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      pl_vec_q   <= 16'h0000;
      pl_phase_q <= 3'h0;
      fail_q     <= 1'b0;
      both_q     <= 1'b0;
      failvec_q  <= 16'h0000;
    end else begin
      pl_phase_q <= (state_q == bstc_pkg::ST_PL_RUN) ? cyc_q : 3'h0;
      if (state_q == bstc_pkg::ST_IDLE) begin
        pl_vec_q <= 16'h0000;
        if (pl_go || ram_go) begin
          fail_q <= 1'b0;
          // both starts at once: only the protocol test runs, both reported failed
          both_q <= pl_go && ram_go;
        end
      end else if (state_q == bstc_pkg::ST_PL_RUN
                   && cyc_q == `BSTC_PL_VEC_CYC) begin
        pl_vec_q <= pl_vec_q + 16'h0001;
        if (pl_mismatch && !fail_q) begin
          fail_q    <= 1'b1;
          failvec_q <= pl_vec_q;
        end
      end else if (state_q == bstc_pkg::ST_MEM_RD
                   && cyc_q == `BSTC_MEM_RD_LAST
                   && mem_rdata != expect_data) begin
        fail_q <= 1'b1;
      end
    end
  end

  // ram side: address and data set up, strobe mid-step, then released
  // limitation: the ram must answer the clock after the read strobe
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      mem_req_q <= '0;
    end else begin
      mem_req_q.we <= 1'b0;
      mem_req_q.re <= 1'b0;
      if (state_q == bstc_pkg::ST_IDLE) begin
        mem_req_q.addr  <= 16'h0000;
        mem_req_q.wdata <= pattern(16'h0000, 1'b0);
      end else if (state_q == bstc_pkg::ST_MEM_WR && !abort) begin
        mem_req_q.wdata <= expect_data;
        mem_req_q.we    <= (cyc_q == 3'h0);
        mem_req_q.re    <= (cyc_q == `BSTC_MEM_WR_LAST);
      end else if (state_q == bstc_pkg::ST_MEM_RD && !abort) begin
        if (cyc_q == `BSTC_MEM_RD_LAST && pass_q && !ram_end)
          mem_req_q.addr <= mem_req_q.addr + 16'h0001;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn)
      test_busy_q <= 1'b0;
    else
      test_busy_q <= (state_q == bstc_pkg::ST_IDLE) ? (pl_go || ram_go)
                     : !(abort || pl_end || ram_end);
  end

  // self-test status word
  // a ram abort leaves no mark here; only the protocol test has one
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      status_q <= `BSTC_STATUS_CLR;
    end else if (state_q == bstc_pkg::ST_IDLE && pl_go) begin
      status_q <= `BSTC_STATUS_CLR;
      status_q[`BSTC_ST_PL_BUSY] <= 1'b1;
      status_q[`BSTC_ST_PL_MARK] <= 1'b1;
    end else if (state_q == bstc_pkg::ST_PL_RUN && abort) begin
      status_q[`BSTC_ST_PL_BUSY]  <= 1'b0;
      status_q[`BSTC_ST_PL_ABORT] <= 1'b1;
    end else if (pl_end) begin
      status_q[`BSTC_ST_PL_BUSY] <= 1'b0;
      status_q[`BSTC_ST_PL_DONE] <= 1'b1;
      status_q[`BSTC_ST_PL_PASS] <= !pl_bad;
      status_q[`BSTC_ST_RAM_FAIL] <= both_q;
    end else if (ram_end) begin
      status_q[`BSTC_ST_RAM_DONE] <= 1'b1;
      status_q[`BSTC_ST_RAM_FAIL] <= fail_q || both_q
                                     || (mem_rdata != expect_data);
    end else if (cmd_wr && wd[`BSTC_CMD_CLR_STAT]) begin
      status_q <= `BSTC_STATUS_CLR;
    end
  end

  // configuration registers; abort acts as a software reset
  // 19h is one register: feature gate in bit 15, halt allow in bit 4
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      cfg6_q   <= `BSTC_CFG_RST;
      cfg37_q  <= `BSTC_CFG_RST;
      imask2_q <= `BSTC_CFG_RST;
    end else if (abort
                 || (cmd_wr && wd[`BSTC_CMD_SWRESET])) begin
      cfg6_q   <= `BSTC_CFG_RST;
      cfg37_q  <= `BSTC_CFG_RST;
      imask2_q <= `BSTC_CFG_RST;
    end else if (wr_hit) begin
      case (reg_req.addr)
        `BSTC_OFF_CFG6:   cfg6_q   <= wd;
        `BSTC_OFF_CFG3:   cfg37_q  <= wd;
        `BSTC_OFF_IMASK2: imask2_q <= wd;
        default: ;
      endcase
    end
  end

  // completion event: a set in the clearing read cycle wins
  // irq trails the event flag by a clock so it leaves a flop
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      istat2_q <= `BSTC_STATUS_CLR;
      irq_q    <= 1'b0;
    end else begin
      if (pl_end || ram_end)
        istat2_q[`BSTC_IST2_DONE] <= 1'b1;
      else if (rd_hit && reg_req.addr == `BSTC_OFF_ISTAT2)
        istat2_q <= `BSTC_STATUS_CLR;
      irq_q <= |(istat2_q & imask2_q);
    end
  end

  // terminal halt: offline after the mode command until resumed or tested
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      halted_q    <= 1'b0;
      from_halt_q <= 1'b0;
    end else begin
      if (start_taken)
        from_halt_q <= halted_q;
      if (init_test_cmd && cfg37_q[`BSTC_CFG7_HALTEN]
          && dev_mode == bstc_pkg::BSTC_TERMINAL)
        halted_q <= 1'b1;
      else if (cmd_wr && wd[`BSTC_CMD_RESUME]
               && state_q == bstc_pkg::ST_IDLE)
        halted_q <= 1'b0;
      else if ((pl_end || ram_end || abort) && from_halt_q)
        halted_q <= 1'b0;
    end
  end

  // output copy of the halt flag; it trails the internal flag by a clock
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn)
      terminal_halted_state <= 1'b0;
    else
      terminal_halted_state <= halted_q;
  end

  // read port: reads never disturb a running test
  // word 20h reads as zero until the wide window is opened
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      reg_rdata_q <= 16'h0000;
    end else if (rd_hit) begin
      case (reg_req.addr)
        `BSTC_OFF_CFG6:   reg_rdata_q <= cfg6_q;
        `BSTC_OFF_CFG3:   reg_rdata_q <= cfg37_q;
        `BSTC_OFF_STATUS: reg_rdata_q <= status_q;
        `BSTC_OFF_IMASK2: reg_rdata_q <= imask2_q;
        `BSTC_OFF_ISTAT2: reg_rdata_q <= istat2_q;
        `BSTC_OFF_FAILVEC:
          reg_rdata_q <= cfg6_q[`BSTC_CFG6_WIN64] ? failvec_q
                         : 16'h0000;
        default:          reg_rdata_q <= 16'h0000;
      endcase
    end else begin
      reg_rdata_q <= 16'h0000;
    end
  end

endmodule : bstc_top

// >>> bstc_top_sva.sv
// assertions on the self-test sequencer ports
`timescale 1ns/1ps
module bstc_top_sva #(
  parameter int PL_VECTORS = 4,
  parameter int MEM_WORDS  = 4
) (
  input wire logic                    sys_clk,        // clock
  input wire logic                    resetn,         // reset
  input wire logic                    master_clear_n, // reset pin
  input wire bstc_pkg::bstc_reg_req_t reg_req,        // host port
  input wire bstc_pkg::bstc_mode_t    dev_mode,       // mode
  input wire logic                    monitor_halted_state, // mon halt
  input wire logic                    init_test_cmd,  // mode command
  input wire logic [2:0]              pl_phase_q,     // vector clock
  input wire bstc_pkg::bstc_mem_req_t mem_req_q,      // ram access
  input wire logic                    test_busy_q,    // running
  input wire logic                    terminal_halted_state // halted
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  logic [19:0] busy_cnt_q;
  wire         cmd_wr = reg_req.wr && reg_req.addr == 6'h03;
  wire         mem_w  = mem_req_q.we;
  wire         term_m = dev_mode inside {bstc_pkg::BSTC_TERMINAL,
                        bstc_pkg::BSTC_MSG_MON, bstc_pkg::BSTC_TERM_MON};
  // length of the last test, read on the cycle busy drops
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) busy_cnt_q <= 20'h0;
    else busy_cnt_q <= test_busy_q ? busy_cnt_q + 20'h1 : 20'h0;
  end
  AST_TEST_LEN: assert property (
    $fell(test_busy_q) && !$past(reg_req.wr) |->
    busy_cnt_q == PL_VECTORS * 8 || busy_cnt_q == MEM_WORDS * 10)
    else $error("test length off");
  AST_PHASE_STEP: assert property (
    pl_phase_q inside {[3'h1:3'h6]} && !reg_req.wr && !$past(reg_req.wr)
    |=> pl_phase_q == $past(pl_phase_q) + 3'h1)
    else $error("vector clock skipped");
  AST_WE_THEN_RE: assert property (
    mem_w |-> ##2 (mem_req_q.re || !test_busy_q))
    else $error("read step not after write step");
  AST_WE_GAP: assert property (mem_w |=> (!mem_w) [*4])
    else $error("ram writes too close");
  AST_PATTERN: assert property (
    mem_w && mem_req_q.wdata == mem_req_q.addr |-> ##5
    (!test_busy_q || mem_w && mem_req_q.wdata == ~mem_req_q.addr))
    else $error("inverted pattern missing");
  AST_ABORT: assert property (test_busy_q && reg_req.wr |=> !test_busy_q)
    else $error("write did not abort test");
  AST_REFUSE: assert property (
    cmd_wr && (reg_req.wdata[7] || reg_req.wdata[9]) && !test_busy_q &&
    term_m && !terminal_halted_state && !monitor_halted_state &&
    !$past(init_test_cmd) |=> !test_busy_q)
    else $error("start not ignored");
  AST_RESUME: assert property (
    terminal_halted_state && !test_busy_q && cmd_wr && reg_req.wdata[11]
    |=> ##1 !terminal_halted_state) else $error("halt not cleared");
  AST_BACK_ONLINE: assert property (
    $fell(test_busy_q) && !$past(reg_req.wr) |=> !terminal_halted_state)
    else $error("still halted after test");
  AST_POWER_ON: assert property (
    $rose(master_clear_n) |-> ##[1:8] test_busy_q)
    else $error("no power-on test");
  AST_SWRESET: assert property (
    cmd_wr && reg_req.wdata == 16'h0001 && !test_busy_q |=> !test_busy_q)
    else $error("software reset started test");
  cover property ($fell(test_busy_q));
  cover property (mem_w);
  cover property ($rose(terminal_halted_state));
  cover property ($fell(terminal_halted_state));
endmodule : bstc_top_sva
bind bstc_top bstc_top_sva #(.PL_VECTORS(PL_VECTORS), .MEM_WORDS(MEM_WORDS))
  bstc_top_sva_inst (.sys_clk(sys_clk), .resetn(resetn),
  .master_clear_n(master_clear_n), .reg_req(reg_req), .dev_mode(dev_mode),
  .pl_phase_q(pl_phase_q), .mem_req_q(mem_req_q), .test_busy_q(test_busy_q),
  .monitor_halted_state(monitor_halted_state), .init_test_cmd(init_test_cmd),
  .terminal_halted_state(terminal_halted_state));

// >>> bstc_top_tb.sv
// self-checking bench for the self-test sequencer
`timescale 1ns/1ps
module bstc_top_tb;
  localparam int PLV = 4; // short counts keep the run brief
  localparam int MW  = 4;
  logic                    sys_clk, resetn, master_clear_n, ram_bad;
  logic                    dev_online, init_test_cmd, pl_mismatch, mon_halt;
  bstc_pkg::bstc_mode_t    dev_mode;
  bstc_pkg::bstc_reg_req_t reg_req;
  bstc_pkg::bstc_mem_req_t mem_req_q;
  logic [15:0]             reg_rdata_q, pl_vec_q, mem_rdata, rv;
  logic [15:0]             ram [4];
  logic [2:0]              pl_phase_q;
  logic                    test_busy_q, terminal_halted_state, irq_q;
  int                      miscompares, checked;
  int unsigned             seed = 95372;
  bstc_top #(.PL_VECTORS(PLV), .MEM_WORDS(MW)) bstc_top_inst (
    .sys_clk(sys_clk), .resetn(resetn), .master_clear_n(master_clear_n),
    .reg_req(reg_req), .reg_rdata_q(reg_rdata_q), .dev_mode(dev_mode),
    .dev_online(dev_online), .monitor_halted_state(mon_halt),
    .init_test_cmd(init_test_cmd), .pl_mismatch(pl_mismatch),
    .pl_vec_q(pl_vec_q), .pl_phase_q(pl_phase_q), .mem_req_q(mem_req_q),
    .mem_rdata(mem_rdata), .test_busy_q(test_busy_q),
    .terminal_halted_state(terminal_halted_state), .irq_q(irq_q));
  bstc_host bstc_host_inst (.sys_clk(sys_clk), .reg_req(reg_req),
    .reg_rdata_q(reg_rdata_q));
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  // ram gives data only after a read strobe, changing junk otherwise
  always @(posedge sys_clk) begin
    if (mem_req_q.we) ram[mem_req_q.addr[1:0]] <= mem_req_q.wdata;
    mem_rdata <= mem_req_q.re ?
      ram[mem_req_q.addr[1:0]] ^ {15'h0, ram_bad} : ~mem_rdata;
  end
  function automatic int unsigned xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs
  task automatic summarize();
    if (miscompares == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : summarize
  task automatic chk(input string n, input logic [15:0] e,
                     input logic [15:0] g);
    checked++;
    if (g !== e) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic wr(input logic [5:0] a, input logic [15:0] d);
    bstc_host_inst.wr(a, d);
    #1;
  endtask : wr
  task automatic rc(input string n, input logic [5:0] a,
                    input logic [15:0] e);
    bstc_host_inst.rd(a, rv);
    chk(n, e, rv);
  endtask : rc
  // a bounded wait is also how the host spots a hung test
  task automatic wait_idle();
    int n;
    n = 0;
    while (test_busy_q !== 1'b0) begin
      @(posedge sys_clk);
      n++;
      if (n > 2000) begin
        miscompares++;
        summarize();
      end
    end
    @(posedge sys_clk);
  endtask : wait_idle
  initial begin
    resetn = 1'b0;
    master_clear_n = 1'b0;
    dev_online = 1'b0;
    init_test_cmd = 1'b0;
    pl_mismatch = 1'b0;
    mon_halt = 1'b0;
    ram_bad = 1'b0;
    dev_mode = bstc_pkg::BSTC_IDLE_MODE;
    mem_rdata = 16'h0;
    repeat (4) @(posedge sys_clk);
    resetn <= 1'b1;
    repeat (2) @(posedge sys_clk);
    master_clear_n <= 1'b1;
    repeat (6) @(posedge sys_clk);
    rc("status", 6'h1c, 16'h4800);
    wait_idle();
    rc("status", 6'h1c, 16'ha800);
    wr(6'h03, 16'h0400);
    rc("status", 6'h1c, 16'h0000);
    wr(6'h03, 16'h0080);
    chk("busy", 16'h0, 16'(test_busy_q));
    wr(6'h19, 16'h8000);
    wr(6'h1d, 16'h0002);
    for (int k = 0; k < 2; k++) begin
      pl_mismatch <= 1'(xs() ^ k);
      wr(6'h03, 16'h0080);
      chk("busy", 16'h1, 16'(test_busy_q));
      wait_idle();
      chk("irq", 16'h1, 16'(irq_q));
      rc("status", 6'h1c, pl_mismatch ? 16'h8800 : 16'ha800);
      rc("istat2", 6'h1e, 16'h0002);
    end
    dev_online <= 1'b1;
    for (int m = 1; m < 6; m++) begin
      dev_mode <= bstc_pkg::bstc_mode_t'(m);
      wr(6'h03, m[0] ? 16'h0080 : 16'h0200);
      chk("busy", 16'h0, 16'(test_busy_q));
    end
    mon_halt <= 1'b1;
    wr(6'h03, 16'h0200);
    chk("busy", 16'h1, 16'(test_busy_q));
    wait_idle();
    mon_halt <= 1'b0;
    dev_online <= 1'b0;
    dev_mode <= bstc_pkg::BSTC_IDLE_MODE;
    wr(6'h03, 16'h0080);
    repeat (9) @(posedge sys_clk);
    #1 chk("vector", 16'h0001, pl_vec_q);
    wr(6'h18, 16'h0004);
    chk("busy", 16'h0, 16'(test_busy_q));
    rc("status", 6'h1c, 16'h1800);
    rc("cfg6", 6'h18, 16'h0000);
    rc("cfg3", 6'h19, 16'h0000);
    rc("window", 6'h20, 16'h0000);
    wr(6'h19, 16'h8000);
    for (int j = 0; j < 2; j++) begin
      ram_bad <= 1'(j);
      wr(6'h03, 16'h0400);
      wr(6'h03, 16'h0200);
      chk("busy", 16'h1, 16'(test_busy_q));
      wait_idle();
      rc("status", 6'h1c, 16'(2 + 4 * j));
    end
    wr(6'h03, 16'h0001);
    chk("busy", 16'h0, 16'(test_busy_q));
    rc("cfg3", 6'h19, 16'h0000);
    wr(6'h19, 16'h8010);
    dev_mode <= bstc_pkg::BSTC_TERMINAL;
    dev_online <= 1'b1;
    for (int h = 0; h < 2; h++) begin
      @(posedge sys_clk);
      init_test_cmd <= 1'b1;
      @(posedge sys_clk);
      init_test_cmd <= 1'b0;
      @(posedge sys_clk);
      #1 chk("halted", 16'h1, 16'(terminal_halted_state));
      wr(6'h03, h ? 16'h0080 : 16'h0800);
      if (h)
        wait_idle();
      else
        @(posedge sys_clk);
      #1 chk("halted", 16'h0, 16'(terminal_halted_state));
    end
    summarize();
  end
endmodule : bstc_top_tb
